// File: rtl/brsc_bridge_ctrl.sv
// Purpose: Bridge control bits 10..3, discard counter, abort mode, display decode
// Assumes: All inputs are logic on the PCI clock; window hits come from elsewhere
// Notes:   Register port: byte address, 16-bit data, read data one cycle later
//
// Contract
// [R01] Discard counter starts only once the delayed completion reaches queue head
// [R02] Counter expiry drops the delayed transaction and sets the expired flag
// [R03] Select bit 0 gives 2^15 clocks, 1 gives 2^10 clocks
// [R04] Secondary master must repeat its retried request within the discard period
// [R05] Primary discard select reads zero and ignores writes
// [R06] Back-to-back enable bit allows fast back-to-back cycles when set
// [R07] Downstream bus reset bit holds the secondary reset output asserted
// [R08] Abort mode 0: master-abort reads return all ones, writes discarded
// [R09] Abort mode 1: PCI master abort becomes unsupported request upstream
// [R10] Abort mode 1: unsupported request completion becomes target abort on PCI
// [R11] Abort mode 1: posted write master abort raises error signaling
// [R12] Full-decode bit chooses whether I/O bits 15:10 are compared
// [R13] Display enable claims memory A0000h..BFFFFh and forwards it downstream
// [R14] Display enable forwards I/O 3B0h-3BBh, 3C0h-3DFh with upper bits zero
// [R15] Display enable blocks these addresses from secondary to primary
// [R16] Display forwarding ignores legacy I/O filter and base/limit windows
// [R17] Display I/O needs I/O enable, display memory needs memory enable
// [R18] Display enable 0: these addresses forwarded only inside configured windows
// [R19] Expired flag reads 1 after a discard, software clears it
// [R20] Repeated request completing stops and clears the discard counter
`timescale 1ns/1ns
`include "brsc_defs.svh"
module brsc_bridge_ctrl
	import brsc_pkg::*;
#(
	parameter logic [15:0] P_DT_LONG  = `BRSC_DT_LONG,
	parameter logic [15:0] P_DT_SHORT = `BRSC_DT_SHORT
) (
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	input  wire logic [7:0]  i_addr,
	input  wire logic [15:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [15:0] o_rdata,
	input  wire logic        i_cpl_at_head,
	input  wire logic        i_retry_done,
	output logic             o_dt_discard,
	input  wire logic        i_req_valid,
	input  wire logic        i_req_upstream,
	input  wire logic        i_req_is_io,
	input  wire logic [31:0] i_req_addr,
	input  wire logic        i_window_hit,
	output logic             o_claim_down,
	output logic             o_block_up,
	input  wire logic        i_pci_mabort,
	input  wire logic        i_mabort_read,
	input  wire logic        i_mabort_posted,
	input  wire logic        i_pcie_ur_cpl,
	output logic             o_fill_ones,
	output logic      [31:0] o_abort_rdata,
	output logic             o_wr_discard,
	output logic             o_ur_up,
	output logic             o_target_abort,
	output logic             o_posted_err,
	output logic             o_sec_reset_n,
	output logic             o_fbb_enable
);

	function automatic logic disp_io_hit(input logic [31:0] a, input logic full);
		logic [9:0] lo;
		logic       in_rng;
		lo = a[9:0];
		in_rng = (lo >= `BRSC_IO_A_LO && lo <= `BRSC_IO_A_HI) ||
			(lo >= `BRSC_IO_B_LO && lo <= `BRSC_IO_B_HI); // [R14]
		return (a[31:16] == 16'h0000) && in_rng && (!full || a[15:10] == 6'h00); // [R12]
	endfunction

	function automatic logic disp_mem_hit(input logic [31:0] a);
		return (a >= `BRSC_MEM_LO) && (a <= `BRSC_MEM_HI); // [R13]
	endfunction

	brsc_top_s s_q;
	brsc_top_s s_d;
	logic      dt_expire;
	logic      dt_running;
	logic      disp_en;
	logic      full_dec;
	logic      abort_reporting_mode;
	logic      leg_hit;
	logic      leg_ok;

	brsc_discard_timer #(
		.P_LONG  (P_DT_LONG),
		.P_SHORT (P_DT_SHORT)
	) u_timer (
		.i_clk        (i_clk),
		.i_nrst       (i_nrst),
		.i_at_head    (i_cpl_at_head), // [R01]
		.i_retry_done (i_retry_done), // [R20]
		.i_short_sel  (s_q.ctl[`BRSC_BC_SECONDARY_DISCARD_SELECT_BIT]), // [R03]
		.o_running    (dt_running),
		.o_expire     (dt_expire)
	);

	assign disp_en  = s_q.ctl[`BRSC_BC_DISP_EN_BIT];
	assign full_dec = s_q.ctl[`BRSC_BC_FULL_DEC_BIT];
	assign abort_reporting_mode      = s_q.ctl[`BRSC_BC_ABORT_BIT];

	always_comb begin
		leg_hit = i_req_is_io ? disp_io_hit(i_req_addr, full_dec) : disp_mem_hit(i_req_addr);
		leg_ok  = i_req_is_io ? s_q.cmd[`BRSC_CMD_IO_BIT] : s_q.cmd[`BRSC_CMD_MEM_BIT]; // [R17]
	end

	always_comb begin
		s_d = s_q;
		s_d.rdata = 16'h0000;
		s_d.fill_ones = 1'b0;
		s_d.abort_rdata = 32'h00000000;
		s_d.wr_discard = 1'b0;
		s_d.ur_up = 1'b0;
		s_d.target_abort = 1'b0;
		s_d.posted_err = 1'b0;
		s_d.claim_down = 1'b0;
		s_d.block_up = 1'b0;
		if (i_wr && i_addr == `BRSC_OFF_COMMAND) begin
			s_d.cmd = i_wdata & `BRSC_CMD_MASK;
		end
		if (i_wr && i_addr == `BRSC_OFF_BRIDGE_CTL) begin
			s_d.ctl = i_wdata & `BRSC_BC_RW_MASK; // [R05]
			if (i_wdata[`BRSC_BC_FLAG_BIT]) begin
				s_d.flag = 1'b0;
			end
		end
		if (dt_expire) begin
			s_d.flag = 1'b1; // [R02] [R19]
		end
		if (i_rd) begin
			case (i_addr)
				`BRSC_OFF_COMMAND: s_d.rdata = s_q.cmd;
				`BRSC_OFF_BRIDGE_CTL: begin
					s_d.rdata = s_q.ctl & `BRSC_BC_RW_MASK; // [R05]
					s_d.rdata[`BRSC_BC_FLAG_BIT] = s_q.flag; // [R19]
				end
				default: s_d.rdata = 16'h0000;
			endcase
		end
		s_d.sec_reset_n = !s_q.ctl[`BRSC_BC_DOWNSTREAM_BUS_RESET_BIT]; // [R07]
		s_d.back_to_back_enable = s_q.ctl[`BRSC_BC_FBB_BIT]; // [R06]
		if (i_req_valid) begin
			if (i_req_upstream) begin
				s_d.block_up = disp_en && leg_hit; // [R15]
			end else begin
				// Display path bypasses the filter bit and the windows
				s_d.claim_down = (disp_en && leg_hit && leg_ok) || i_window_hit; // [R16] [R18]
			end
		end
		if (i_pci_mabort) begin
			if (!abort_reporting_mode) begin
				s_d.fill_ones = i_mabort_read; // [R08]
				s_d.abort_rdata = i_mabort_read ? `BRSC_ALL_ONES : 32'h00000000;
				s_d.wr_discard = !i_mabort_read; // [R08]
			end else begin
				s_d.ur_up = !i_mabort_posted; // [R09]
				s_d.posted_err = i_mabort_posted; // [R11]
			end
		end
		if (i_pcie_ur_cpl) begin
			if (abort_reporting_mode) begin
				s_d.target_abort = 1'b1; // [R10]
			end else begin
				s_d.fill_ones = 1'b1; // [R08]
				s_d.abort_rdata = `BRSC_ALL_ONES;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			s_q <= '0;
			s_q.ctl <= `BRSC_BC_RESET;
			s_q.cmd <= `BRSC_CMD_RESET;
			s_q.sec_reset_n <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_rdata        = s_q.rdata;
	assign o_dt_discard   = dt_expire;
	assign o_claim_down   = s_q.claim_down;
	assign o_block_up     = s_q.block_up;
	assign o_fill_ones    = s_q.fill_ones;
	assign o_abort_rdata  = s_q.abort_rdata;
	assign o_wr_discard   = s_q.wr_discard;
	assign o_ur_up        = s_q.ur_up;
	assign o_target_abort = s_q.target_abort;
	assign o_posted_err   = s_q.posted_err;
	assign o_sec_reset_n  = s_q.sec_reset_n;
	assign o_fbb_enable   = s_q.back_to_back_enable;

	sequence s_ctl_write_bit(int b, logic v);
		i_wr && i_addr == `BRSC_OFF_BRIDGE_CTL && i_wdata[b] == v;
	endsequence

	a_flag_set: assert property (@(posedge i_clk) disable iff (!i_nrst) // [R19]
		dt_expire |=> s_q.flag)
		else $error("discard expiry did not set the flag");

	a_pri_zero: assert property (@(posedge i_clk) disable iff (!i_nrst) // [R05]
		i_rd && i_addr == `BRSC_OFF_BRIDGE_CTL |=> !o_rdata[`BRSC_BC_PRI_DT_BIT])
		else $error("primary discard select read nonzero");

	a_sec_reset: assert property (@(posedge i_clk) disable iff (!i_nrst) // [R07]
		s_ctl_write_bit(`BRSC_BC_DOWNSTREAM_BUS_RESET_BIT, 1'b1) |=> ##1 !o_sec_reset_n)
		else $error("secondary reset not asserted");

	a_fbb_follow: assert property (@(posedge i_clk) disable iff (!i_nrst) // [R06]
		s_ctl_write_bit(`BRSC_BC_FBB_BIT, 1'b0) |=> ##1 !o_fbb_enable)
		else $error("back-to-back enable did not clear");

	a_ones_read: assert property (@(posedge i_clk) disable iff (!i_nrst) // [R08]
		i_pci_mabort && i_mabort_read && !abort_reporting_mode && !i_pcie_ur_cpl
		|=> o_fill_ones && o_abort_rdata == `BRSC_ALL_ONES && !o_ur_up)
		else $error("master-abort read did not return all ones");

	a_ur_up: assert property (@(posedge i_clk) disable iff (!i_nrst) // [R09]
		i_pci_mabort && abort_reporting_mode && !i_mabort_posted |=> o_ur_up && !o_fill_ones)
		else $error("master abort not returned as unsupported request");

	a_tgt_abort: assert property (@(posedge i_clk) disable iff (!i_nrst) // [R10]
		i_pcie_ur_cpl && abort_reporting_mode |=> o_target_abort)
		else $error("unsupported request not turned into target abort");

	a_posted_err: assert property (@(posedge i_clk) disable iff (!i_nrst) // [R11]
		o_posted_err |-> $past(i_pci_mabort) && $past(abort_reporting_mode) && $past(i_mabort_posted))
		else $error("posted error signaled without cause");

	a_mem_claim: assert property (@(posedge i_clk) disable iff (!i_nrst) // [R13]
		i_req_valid && !i_req_upstream && !i_req_is_io && disp_en &&
		s_q.cmd[`BRSC_CMD_MEM_BIT] && disp_mem_hit(i_req_addr) |=> o_claim_down)
		else $error("display memory access not claimed");

	a_up_block: assert property (@(posedge i_clk) disable iff (!i_nrst) // [R15]
		o_block_up |-> $past(disp_en) && $past(i_req_upstream) && !o_claim_down)
		else $error("upstream block without display enable");

	a_no_claim: assert property (@(posedge i_clk) disable iff (!i_nrst) // [R18]
		i_req_valid && !i_req_upstream && !disp_en && !i_window_hit |=> !o_claim_down)
		else $error("display address forwarded outside windows");

endmodule // brsc_bridge_ctrl

// File: rtl/brsc_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 50 MHz PCI clock, byte offsets on the register port
// Notes:   Included by its bare name
`ifndef BRSC_DEFS_SVH
`define BRSC_DEFS_SVH

`define BRSC_OFF_COMMAND     8'h04
`define BRSC_OFF_BRIDGE_CTL  8'h3e

`define BRSC_CMD_IO_BIT      0
`define BRSC_CMD_MEM_BIT     1
`define BRSC_CMD_MASK        16'h0003
`define BRSC_CMD_RESET       16'h0000

`define BRSC_BC_LEG_IO_BIT   2
`define BRSC_BC_DISP_EN_BIT  3
`define BRSC_BC_FULL_DEC_BIT 4
`define BRSC_BC_ABORT_BIT    5
`define BRSC_BC_DOWNSTREAM_BUS_RESET_BIT     6
`define BRSC_BC_FBB_BIT      7
`define BRSC_BC_PRI_DT_BIT   8
`define BRSC_BC_SECONDARY_DISCARD_SELECT_BIT   9
`define BRSC_BC_FLAG_BIT     10
`define BRSC_BC_RW_MASK      16'h0aff
`define BRSC_BC_RESET        16'h0000

`define BRSC_DT_LONG         16'h8000
`define BRSC_DT_SHORT        16'h0400

`define BRSC_MEM_LO          32'h000a0000
`define BRSC_MEM_HI          32'h000bffff
`define BRSC_IO_A_LO         10'h3b0
`define BRSC_IO_A_HI         10'h3bb
`define BRSC_IO_B_LO         10'h3c0
`define BRSC_IO_B_HI         10'h3df
`define BRSC_ALL_ONES        32'hffffffff

`endif

// File: rtl/brsc_pkg.sv
// Purpose: Types shared by the secondary control logic
// Assumes: Widths fixed by the documented counter lengths
// Notes:   State of each module is one packed struct
package brsc_pkg;

	typedef enum logic [0:0] {DT_IDLE, DT_RUN} brsc_dt_state_e;

	typedef struct packed {
		brsc_dt_state_e state;
		logic [15:0]    cnt;
		logic [15:0]    lim;
		logic           expire;
	} brsc_dt_s;

	typedef struct packed {
		logic [15:0] cmd;
		logic [15:0] ctl;
		logic        flag;
		logic [15:0] rdata;
		logic        sec_reset_n;
		logic        back_to_back_enable;
		logic        claim_down;
		logic        block_up;
		logic        fill_ones;
		logic [31:0] abort_rdata;
		logic        wr_discard;
		logic        ur_up;
		logic        target_abort;
		logic        posted_err;
	} brsc_top_s;

endpackage : brsc_pkg

// File: rtl/brsc_discard_timer.sv
// Purpose: Secondary discard counter for one delayed completion
// Assumes: Start and retry inputs come from logic on the same clock
// Notes:   Length latched when counting starts
`timescale 1ns/1ns
`include "brsc_defs.svh"
module brsc_discard_timer
	import brsc_pkg::*;
#(
	parameter logic [15:0] P_LONG  = `BRSC_DT_LONG,
	parameter logic [15:0] P_SHORT = `BRSC_DT_SHORT
) (
	input  wire logic i_clk,
	input  wire logic i_nrst,
	input  wire logic i_at_head,
	input  wire logic i_retry_done,
	input  wire logic i_short_sel,
	output logic      o_running,
	output logic      o_expire
);

	brsc_dt_s s_q;
	brsc_dt_s s_d;

	always_comb begin
		s_d = s_q;
		s_d.expire = 1'b0;
		case (s_q.state)
			DT_IDLE: begin
				if (i_at_head) begin // [R01]
					s_d.state = DT_RUN;
					s_d.cnt = 16'h0000;
					s_d.lim = i_short_sel ? P_SHORT : P_LONG; // [R03]
				end
			end
			DT_RUN: begin
				if (i_retry_done) begin // [R20]
					s_d.state = DT_IDLE;
					s_d.cnt = 16'h0000;
				end else if (s_q.cnt == s_q.lim - 16'h0001) begin // [R02]
					s_d.state = DT_IDLE;
					s_d.expire = 1'b1;
				end else begin
					s_d.cnt = s_q.cnt + 16'h0001;
				end
			end
			default: s_d.state = DT_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_running = (s_q.state == DT_RUN);
	assign o_expire  = s_q.expire;

	a_start_head: assert property (@(posedge i_clk) disable iff (!i_nrst) // [R01]
		$rose(o_running) |-> $past(i_at_head))
		else $error("discard counter started without completion at head");

	a_short_len: assert property (@(posedge i_clk) disable iff (!i_nrst) // [R03]
		o_expire && s_q.lim == P_SHORT |-> $past(s_q.cnt) == P_SHORT - 16'h0001)
		else $error("short discard period has wrong length");

	a_retry_stop: assert property (@(posedge i_clk) disable iff (!i_nrst) // [R20]
		o_running && i_retry_done |=> !o_running && !o_expire)
		else $error("repeated request did not stop the discard counter");

endmodule // brsc_discard_timer

// File: dv/brsc_sec_master.sv
// Purpose: Secondary master that repeats a retried delayed request
// Assumes: Repeat delay and give-up choice are set by the bench
// Notes:   Drives the repeat-done pulse seen by the bridge
`timescale 1ns/1ns
module brsc_sec_master (
	input  wire logic       i_clk,
	input  wire logic       i_nrst,
	input  wire logic       i_retried,
	input  wire logic [7:0] i_delay,
	input  wire logic       i_give_up,
	output logic            o_repeat_done
);
	logic [7:0] wait_q;

	// Repeats the request after i_delay clocks unless told to give up
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			wait_q        <= 8'h00;
			o_repeat_done <= 1'b0;
		end else begin
			o_repeat_done <= (wait_q == 8'h01);
			if (i_retried && !i_give_up)
				wait_q <= i_delay;
			else if (wait_q != 8'h00)
				wait_q <= wait_q - 8'h01;
		end
	end
endmodule // brsc_sec_master

// File: dv/tb_top.sv
// Purpose: Bench for the bridge secondary control block
// Assumes: Discard lengths shortened to 64 and 16 clocks
// Notes:   Register tasks, table-driven decode and abort checks
`timescale 1ns/1ns
module tb_top;
	logic        i_clk  = 1'b0;
	logic        i_nrst = 1'b0;
	logic [7:0]  addr   = 8'h00;
	logic [15:0] wdata  = 16'h0000;
	logic        wr = 1'b0, rd = 1'b0, cpl = 1'b0, rty = 1'b0, gu = 1'b1;
	logic        rv = 1'b0, up = 1'b0, io = 1'b0, hit = 1'b0;
	logic        mab = 1'b0, mrd = 1'b0, mpo = 1'b0, ur = 1'b0;
	logic [31:0] ra = 32'h0;
	logic [31:0] abd;
	logic [15:0] rdata;
	logic        rdone, dsc, claim, blk, fill, wdis, urup, tab, perr, srn, fbb;
	int          err_count  = 0;
	int          num_checks = 0;

	always #10 i_clk = ~i_clk;

	brsc_bridge_ctrl #(.P_DT_LONG(16'h0040), .P_DT_SHORT(16'h0010)) uut (
		.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_cpl_at_head(cpl),
		.i_retry_done(rdone), .o_dt_discard(dsc), .i_req_valid(rv),
		.i_req_upstream(up), .i_req_is_io(io), .i_req_addr(ra),
		.i_window_hit(hit), .o_claim_down(claim), .o_block_up(blk),
		.i_pci_mabort(mab), .i_mabort_read(mrd), .i_mabort_posted(mpo),
		.i_pcie_ur_cpl(ur), .o_fill_ones(fill), .o_abort_rdata(abd),
		.o_wr_discard(wdis), .o_ur_up(urup), .o_target_abort(tab),
		.o_posted_err(perr), .o_sec_reset_n(srn), .o_fbb_enable(fbb));

	brsc_sec_master far (.i_clk(i_clk), .i_nrst(i_nrst), .i_retried(rty),
		.i_delay(8'h05), .i_give_up(gu), .o_repeat_done(rdone));

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wreg(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_clk);
		{wr, addr, wdata} <= {1'b1, a, d};
		@(posedge i_clk);
		wr <= 1'b0;
	endtask

	task automatic rreg(input logic [7:0] a, input logic [15:0] e);
		@(posedge i_clk);
		{rd, addr} <= {1'b1, a};
		@(posedge i_clk);
		rd <= 1'b0;
		#1;
		chk("rdata", {16'h0, e}, {16'h0, rdata});
	endtask

	task automatic outs(input logic [1:0] e);
		repeat (2) @(posedge i_clk);
		#1;
		chk("reset_fbb", {30'h0, e}, {30'h0, srn, fbb});
	endtask

	// Counts clocks from the start edge to the discard pulse, 100 means none
	task automatic disc(input logic g, input int e);
		int n;
		@(posedge i_clk);
		{cpl, rty, gu} <= {2'b11, g};
		@(posedge i_clk);
		{cpl, rty} <= 2'b00;
		n = 0;
		while (n < 100) begin
			@(posedge i_clk);
			#1;
			n++;
			if (dsc === 1'b1)
				break;
		end
		chk("discard_clocks", e, n);
	endtask

	task automatic dec(input logic [1:0] k, input logic [31:0] a, input logic h,
			input logic [1:0] e);
		@(posedge i_clk);
		{rv, up, io, ra, hit} <= {1'b1, k, a, h};
		@(posedge i_clk);
		rv <= 1'b0;
		#1;
		chk("claim_block", {30'h0, e}, {30'h0, claim, blk});
	endtask

	task automatic abt(input logic [3:0] v, input logic [4:0] e);
		@(posedge i_clk);
		{mab, mrd, mpo, ur} <= v;
		@(posedge i_clk);
		{mab, mrd, mpo, ur} <= 4'h0;
		#1;
		chk("abort", {27'h0, e}, {27'h0, fill, wdis, urup, tab, perr});
		chk("abort_rdata", e[4] ? 32'hffffffff : 32'h0, abd);
	endtask

	task automatic print_verdict;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		#200000;
		err_count++;
		print_verdict();
	end

	initial begin
		repeat (8) @(posedge i_clk);
		i_nrst <= 1'b1;
		outs(2'b10);
		rreg(8'h04, 16'h0000);
		rreg(8'h3e, 16'h0000);
		wreg(8'h3e, 16'hffff);
		outs(2'b01);
		rreg(8'h3e, 16'h0aff);
		rreg(8'h10, 16'h0000);
		wreg(8'h3e, 16'h0000);
		outs(2'b10);
		wreg(8'h3e, 16'h0200);
		disc(1'b1, 16);
		rreg(8'h3e, 16'h0600);
		wreg(8'h3e, 16'h0600);
		rreg(8'h3e, 16'h0200);
		wreg(8'h3e, 16'h0000);
		disc(1'b1, 64);
		rreg(8'h3e, 16'h0400);
		wreg(8'h3e, 16'h0400);
		disc(1'b0, 100);
		rreg(8'h3e, 16'h0000);
		abt(4'hc, 5'h10);
		abt(4'ha, 5'h08);
		abt(4'h1, 5'h10);
		wreg(8'h3e, 16'h0020);
		abt(4'hc, 5'h04);
		abt(4'h8, 5'h04);
		abt(4'h1, 5'h02);
		abt(4'ha, 5'h01);
		wreg(8'h04, 16'hffff);
		rreg(8'h04, 16'h0003);
		wreg(8'h3e, 16'h0008);
		dec(2'b00, 32'ha0000, 1'b0, 2'b10);
		dec(2'b00, 32'hbffff, 1'b0, 2'b10);
		dec(2'b00, 32'hc0000, 1'b0, 2'b00);
		dec(2'b00, 32'h9ffff, 1'b0, 2'b00);
		dec(2'b01, 32'h3bb, 1'b0, 2'b10);
		dec(2'b01, 32'h3bc, 1'b0, 2'b00);
		dec(2'b01, 32'h3c0, 1'b0, 2'b10);
		dec(2'b01, 32'h3df, 1'b0, 2'b10);
		dec(2'b01, 32'h3e0, 1'b0, 2'b00);
		dec(2'b01, 32'h103b0, 1'b0, 2'b00);
		dec(2'b01, 32'h7fb0, 1'b0, 2'b10);
		dec(2'b10, 32'ha0000, 1'b0, 2'b01);
		dec(2'b11, 32'h3c0, 1'b0, 2'b01);
		wreg(8'h3e, 16'h0018);
		dec(2'b01, 32'h7fb0, 1'b0, 2'b00);
		dec(2'b01, 32'h3b0, 1'b0, 2'b10);
		wreg(8'h3e, 16'h000c);
		dec(2'b01, 32'h73b0, 1'b0, 2'b10);
		wreg(8'h04, 16'h0001);
		dec(2'b00, 32'ha0000, 1'b0, 2'b00);
		dec(2'b01, 32'h3b0, 1'b0, 2'b10);
		wreg(8'h04, 16'h0002);
		dec(2'b00, 32'ha0000, 1'b0, 2'b10);
		dec(2'b01, 32'h3b0, 1'b0, 2'b00);
		dec(2'b10, 32'ha0000, 1'b0, 2'b01);
		wreg(8'h3e, 16'h0000);
		dec(2'b00, 32'ha0000, 1'b0, 2'b00);
		dec(2'b00, 32'ha0000, 1'b1, 2'b10);
		dec(2'b10, 32'ha0000, 1'b0, 2'b00);
		print_verdict();
	end
endmodule // tb_top
